// *** core/dram_pwr_ctrl.sv ***
// Controller side of DRAM power-down and self-refresh sequencing
`timescale 1ns/1ps
`default_nettype none
module dram_pwr_ctrl #(
   parameter int TIMER_W = dram_pwr_pkg::TIMER_W_DEFAULT,
   parameter int XSNR_CYCLES = dram_pwr_pkg::XSNR_CLK_DEFAULT,
   parameter int REFI_CYCLES = dram_pwr_pkg::REFI_CLK_DEFAULT
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Power requests and memory status from the user
   input wire logic PD_REQ,
   input wire logic SR_REQ,
   input wire logic BANK_OPEN,
   input wire logic OP_BUSY,
   input wire logic CAL_MODE,
   // Termination wishes
   input wire logic TERM_EN,
   input wire logic TERM_LEVEL,
   // User command and write mask
   input wire logic CMD_VALID,
   input wire dram_pwr_pkg::cmd_t CMD_IN,
   output logic CMD_READY,
   input wire logic MASK_IN,
   // Memory pins
   output logic CKE,
   output logic CS_N,
   output logic RAS_N,
   output logic CAS_N,
   output logic WE_N,
   output logic TERMINATION_CONTROL,
   output logic WRITE_MASK,
   // Status
   output dram_pwr_pkg::pwr_state_t PWR_STATE,
   output logic READ_OK
);
   import dram_pwr_pkg::*;

   localparam int PD_MAX_CYCLES = PD_LIMIT_REFI * REFI_CYCLES;
   localparam int CKE_RUN_MIN = CKE_MIN_CLK - 1;

   pwr_state_t state_r;
   pwr_state_t state_nxt;
   logic cke_r;
   logic cke_nxt;
   cmd_t cmd_r;
   logic term_r;
   logic mask_r;
   logic entry_ok;
   logic sr_go;
   logic pd_go;
   logic pd_leave;
   logic sr_leave;
   logic xs_done;

   cnt_if #(.W(TIMER_W)) cke_tif();
   cnt_if #(.W(TIMER_W)) long_tif();
   cnt_if #(.W(TIMER_W)) read_tif();

   // Minimum clock-enable pulse timer
   hold_timer #(.W(TIMER_W)) u_cke_tmr (
      .clk(CLK),
      .rst_n(RST_N),
      .tif(cke_tif)
   );

   // Power-down limit and self-refresh non-read exit timer
   hold_timer #(.W(TIMER_W)) u_long_tmr (
      .clk(CLK),
      .rst_n(RST_N),
      .tif(long_tif)
   );

   // Self-refresh read exit timer
   hold_timer #(.W(TIMER_W)) u_read_tmr (
      .clk(CLK),
      .rst_n(RST_N),
      .tif(read_tif)
   );

   // Entry only from steady normal operation with nothing pending
   assign entry_ok = (state_r == ST_NORMAL) && cke_r && cke_tif.zero && !OP_BUSY
                     && !CAL_MODE && !CMD_VALID;
   assign sr_go = entry_ok && SR_REQ && !BANK_OPEN;
   assign pd_go = entry_ok && PD_REQ && !sr_go;
   assign pd_leave = (state_r == ST_POWER_DOWN) && cke_tif.zero
                     && (!PD_REQ || long_tif.zero);
   assign sr_leave = (state_r == ST_SELF_REF) && cke_tif.zero && !SR_REQ;
   assign xs_done = (state_r == ST_SR_EXIT) && long_tif.zero;

   // Timer loads
   assign cke_tif.load = sr_go || pd_go || pd_leave || sr_leave;
   assign cke_tif.value = TIMER_W'(CKE_MIN_CLK - 1);
   assign long_tif.load = pd_go || sr_leave;
   assign long_tif.value = pd_go ? TIMER_W'(PD_MAX_CYCLES - 1)
                                 : TIMER_W'(XSNR_CYCLES - 1);
   assign read_tif.load = sr_leave;
   assign read_tif.value = TIMER_W'(SR_READ_DELAY_CLK - 1);

   // User commands pass only in normal state; reads wait for the exit delay
   assign CMD_READY = (state_r == ST_NORMAL) && cke_r
                      && (!is_read_cmd(CMD_IN) || read_tif.zero);
   assign READ_OK = read_tif.zero;

   // Next power state, tracking what the memory does on each edge
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_NORMAL: begin
            if (sr_go) begin
               state_nxt = ST_SELF_REF;
            end else if (pd_go) begin
               state_nxt = ST_POWER_DOWN;
            end
         end
         ST_POWER_DOWN: begin
            if (pd_leave) begin
               state_nxt = ST_NORMAL;
            end
         end
         ST_SELF_REF: begin
            if (sr_leave) begin
               state_nxt = ST_SR_EXIT;
            end
         end
         ST_SR_EXIT: begin
            if (xs_done) begin
               state_nxt = ST_NORMAL;
            end
         end
      endcase
   end

   // Clock-enable level
   always_comb begin
      cke_nxt = cke_r;
      if (sr_go || pd_go) begin
         cke_nxt = 1'b0;
      end else if (pd_leave || sr_leave) begin
         cke_nxt = 1'b1;
      end
   end

   // Power state register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= ST_NORMAL;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Clock-enable register; high on both edges keeps normal decoding
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cke_r <= RST_CKE;
      end else begin
         cke_r <= cke_nxt;
      end
   end

   // Command register: refresh for self-refresh entry, else user or no-op
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cmd_r <= RST_CMD;
      end else if (sr_go) begin
         cmd_r <= CMD_REFRESH;
      end else if (CMD_VALID && CMD_READY) begin
         cmd_r <= CMD_IN;
      end else begin
         cmd_r <= CMD_NOP;
      end
   end

   // Termination level is always driven; held low in self-refresh where it has no use
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         term_r <= 1'b0;
      end else if (state_nxt == ST_SELF_REF) begin
         term_r <= 1'b0;
      end else begin
         term_r <= TERM_EN && TERM_LEVEL;
      end
   end

   // Write mask travels with its data beat
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mask_r <= 1'b0;
      end else begin
         mask_r <= MASK_IN;
      end
   end

   assign CKE = cke_r;
   assign CS_N = cmd_r[3];
   assign RAS_N = cmd_r[2];
   assign CAS_N = cmd_r[1];
   assign WE_N = cmd_r[0];
   assign TERMINATION_CONTROL = term_r;
   assign WRITE_MASK = mask_r;
   assign PWR_STATE = state_r;

   // Helper counters watched by the checks below
   int cke_run_r;
   int pd_run_r;
   int since_exit_r;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cke_run_r <= 255;
         pd_run_r <= 0;
         since_exit_r <= 255;
      end else begin
         cke_run_r <= (cke_nxt != cke_r) ? 0 : ((cke_run_r < 255) ? cke_run_r + 1 : 255);
         pd_run_r <= (state_nxt == ST_POWER_DOWN) ? pd_run_r + 1 : 0;
         since_exit_r <= sr_leave ? 0 : ((since_exit_r < 255) ? since_exit_r + 1 : 255);
      end
   end

   property p_exit_idle;
      @(posedge CLK) disable iff (!RST_N)
      $rose(cke_r) |-> is_idle_cmd(cmd_r);
   endproperty
   a_exit_idle: assert property (p_exit_idle) else $error("exit edge without no-op");

   property p_pd_entry_idle;
      @(posedge CLK) disable iff (!RST_N)
      $fell(cke_r) && (state_r == ST_POWER_DOWN) |-> is_idle_cmd(cmd_r);
   endproperty
   a_pd_entry_idle: assert property (p_pd_entry_idle) else $error("bad power-down entry");

   property p_sr_entry;
      @(posedge CLK) disable iff (!RST_N)
      $fell(cke_r) && (state_r == ST_SELF_REF) |-> (cmd_r == CMD_REFRESH) && !$past(BANK_OPEN);
   endproperty
   a_sr_entry: assert property (p_sr_entry) else $error("bad self-refresh entry");

   property p_xsnr_idle;
      @(posedge CLK) disable iff (!RST_N)
      (state_r == ST_SR_EXIT) |-> is_idle_cmd(cmd_r) ##1 ((state_r == ST_SR_EXIT) || is_idle_cmd(cmd_r));
   endproperty
   a_xsnr_idle: assert property (p_xsnr_idle) else $error("command during exit delay");

   property p_read_delay;
      @(posedge CLK) disable iff (!RST_N)
      is_read_cmd(cmd_r) |-> (since_exit_r >= SR_READ_DELAY_CLK);
   endproperty
   a_read_delay: assert property (p_read_delay) else $error("read too soon after exit");

   property p_no_busy_entry;
      @(posedge CLK) disable iff (!RST_N)
      $fell(cke_r) |-> !$past(OP_BUSY) && !$past(CAL_MODE);
   endproperty
   a_no_busy_entry: assert property (p_no_busy_entry) else $error("entry while busy");

   property p_cke_min;
      @(posedge CLK) disable iff (!RST_N)
      $changed(cke_r) |-> $past(cke_run_r) >= CKE_RUN_MIN;
   endproperty
   a_cke_min: assert property (p_cke_min) else $error("clock-enable pulse too short");

   property p_cal_high;
      @(posedge CLK) disable iff (!RST_N)
      cke_r && CAL_MODE |=> cke_r;
   endproperty
   a_cal_high: assert property (p_cal_high) else $error("enable dropped in calibration");

   property p_pd_limit;
      @(posedge CLK) disable iff (!RST_N)
      pd_run_r <= PD_MAX_CYCLES;
   endproperty
   a_pd_limit: assert property (p_pd_limit) else $error("power-down too long");

   property p_term_valid;
      @(posedge CLK) disable iff (!RST_N)
      (state_r == ST_POWER_DOWN) && ($past(state_r) == ST_POWER_DOWN)
         |-> term_r == ($past(TERM_EN) && $past(TERM_LEVEL));
   endproperty
   a_term_valid: assert property (p_term_valid) else $error("termination not driven");

   property p_low_legal;
      @(posedge CLK) disable iff (!RST_N)
      !cke_r |-> is_idle_cmd(cmd_r) || ($fell(cke_r) && (cmd_r == CMD_REFRESH));
   endproperty
   a_low_legal: assert property (p_low_legal) else $error("illegal command with enable low");

endmodule: dram_pwr_ctrl
`default_nettype wire

// *** core/dram_pwr_pkg.sv ***
// Constants, types and helpers for the DRAM clock-enable power-state controller
package dram_pwr_pkg;

   // Command is {chip select, row strobe, column strobe, write enable}, all active low
   typedef logic [3:0] cmd_t;

   typedef enum logic [1:0] {
      ST_NORMAL     = 2'b00,
      ST_POWER_DOWN = 2'b01,
      ST_SELF_REF   = 2'b10,
      ST_SR_EXIT    = 2'b11
   } pwr_state_t;

   localparam cmd_t CMD_NOP = 4'h7;
   localparam cmd_t CMD_DESELECT = 4'hf;
   localparam cmd_t CMD_REFRESH = 4'h1;
   localparam cmd_t CMD_READ = 4'h5;

   // Timing in clocks of the memory clock; PD_LIMIT_REFI counts refresh intervals and TIMER_W_DEFAULT is a width in bits
   localparam int CKE_MIN_CLK = 3;
   localparam int SR_READ_DELAY_CLK = 200;
   localparam int XSNR_CLK_DEFAULT = 16;
   localparam int REFI_CLK_DEFAULT = 512;
   localparam int PD_LIMIT_REFI = 9;
   localparam int TIMER_W_DEFAULT = 16;

   // Values after reset
   localparam logic RST_CKE = 1'b1;
   localparam cmd_t RST_CMD = CMD_NOP;

   // True for a command that is a no-operation or a deselect
   function automatic logic is_idle_cmd(input cmd_t c);
      return c[3] || (c == CMD_NOP);
   endfunction: is_idle_cmd

   // True for a read, with or without auto precharge
   function automatic logic is_read_cmd(input cmd_t c);
      return c == CMD_READ;
   endfunction: is_read_cmd

endpackage: dram_pwr_pkg

// *** core/cnt_if.sv ***
// Load and zero handshake between the controller and a hold timer
`timescale 1ns/1ps
`default_nettype none
interface cnt_if #(parameter int W = 16);
   logic load;
   logic [W-1:0] value;
   logic zero;
   modport ctl(output load, output value, input zero);
   modport cnt(input load, input value, output zero);
endinterface: cnt_if
`default_nettype wire

// *** core/hold_timer.sv ***
// Loadable down counter that reports when it has run out
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control side
   cnt_if.cnt tif
);
   logic [W-1:0] count_r;

   // Load wins over the count; stops at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
      end else if (tif.load) begin
         count_r <= tif.value;
      end else if (count_r != '0) begin
         count_r <= count_r - 1'b1;
      end
   end

   assign tif.zero = (count_r == '0);
endmodule: hold_timer
`default_nettype wire

// *** tb/dram_dev_model.sv ***
// Behavioural memory device that tracks power state and counts controller slips
`timescale 1ns/1ps
`default_nettype none
module dram_dev_model #(
   parameter int XSNR = 16,
   parameter int PD_MAX = 36
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Memory pins
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic term,
   input wire logic wmask,
   // Bank status as the bench knows it
   input wire logic bank_open,
   // Observed device behaviour
   output logic [1:0] dev_state,
   output logic term_on,
   output logic wr_keep,
   output logic [7:0] viol_cnt
);
   import dram_pwr_pkg::*;
   logic prev_cke_r;
   logic [15:0] run_r;
   logic [15:0] since_r;
   logic [15:0] pd_r;
   cmd_t cmd;
   logic idle;
   // Command decode
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign idle = cs_n || (cmd == CMD_NOP);
   assign term_on = term && (dev_state != 2'h3);
   assign wr_keep = !wmask;
   // State: 0 normal, 1 active down, 2 precharge down, 3 self-refresh
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_cke_r <= 1'b1;
         dev_state <= 2'h0;
         viol_cnt <= 8'h00;
         run_r <= 16'h0003;
         since_r <= 16'hffff;
         pd_r <= 16'h0000;
      end else begin
         prev_cke_r <= cke;
         run_r <= (cke != prev_cke_r) ? 16'h0001 : run_r + 16'h0001;
         since_r <= (since_r == 16'hffff) ? since_r : since_r + 16'h0001;
         pd_r <= (dev_state == 2'h1 || dev_state == 2'h2) ? pd_r + 16'h0001 : 16'h0000;
         if ((cke != prev_cke_r) && (run_r < CKE_MIN_CLK)) viol_cnt <= viol_cnt + 8'h01;
         if (pd_r > PD_MAX) viol_cnt <= viol_cnt + 8'h01;
         if (prev_cke_r && !cke) begin
            if (cmd == CMD_REFRESH && !bank_open) dev_state <= 2'h3;
            else if (idle) dev_state <= bank_open ? 2'h1 : 2'h2;
            else viol_cnt <= viol_cnt + 8'h01;
         end else if (!prev_cke_r && cke) begin
            if (!idle) viol_cnt <= viol_cnt + 8'h01;
            if (dev_state == 2'h3) since_r <= 16'h0001;
            dev_state <= 2'h0;
         end else if (prev_cke_r && cke) begin
            if (since_r < XSNR && !idle) viol_cnt <= viol_cnt + 8'h01;
            if (since_r < SR_READ_DELAY_CLK && is_read_cmd(cmd)) viol_cnt <= viol_cnt + 8'h01;
         end
      end
   end
endmodule: dram_dev_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the power-state controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dram_pwr_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pd_req = 1'b0, sr_req = 1'b0, bank_open = 1'b0, op_busy = 1'b0, cal_mode = 1'b0;
   logic term_en = 1'b0, term_level = 1'b0, cmd_valid = 1'b0, mask_in = 1'b0;
   cmd_t cmd_in = CMD_NOP;
   logic cmd_ready, cke, cs_n, ras_n, cas_n, we_n, term_ctl, wr_mask, read_ok;
   logic term_on, wr_keep;
   logic [1:0] dev_state;
   logic [7:0] viol_cnt;
   pwr_state_t pwr_state;
   int error_cnt = 0;
   int num_checks = 0;
   // Clock
   always #5 clk = ~clk;
   // Controller under test, power-down limit shortened to 36 cycles
   dram_pwr_ctrl #(.REFI_CYCLES(4)) uut (.CLK(clk), .RST_N(rst_n), .PD_REQ(pd_req),
      .SR_REQ(sr_req), .BANK_OPEN(bank_open), .OP_BUSY(op_busy), .CAL_MODE(cal_mode),
      .TERM_EN(term_en), .TERM_LEVEL(term_level), .CMD_VALID(cmd_valid), .CMD_IN(cmd_in),
      .CMD_READY(cmd_ready), .MASK_IN(mask_in), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
      .CAS_N(cas_n), .WE_N(we_n), .TERMINATION_CONTROL(term_ctl), .WRITE_MASK(wr_mask),
      .PWR_STATE(pwr_state), .READ_OK(read_ok));
   // Memory device model
   dram_dev_model #(.XSNR(16), .PD_MAX(36)) dev (.clk(clk), .rst_n(rst_n), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .term(term_ctl),
      .wmask(wr_mask), .bank_open(bank_open), .dev_state(dev_state), .term_on(term_on),
      .wr_keep(wr_keep), .viol_cnt(viol_cnt));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask: chk
   // Waits a bounded time for the reported power state
   task wait_st(input pwr_state_t s);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (pwr_state !== s && n < 500);
      chk(16'(pwr_state), 16'(s));
   endtask: wait_st
   task tally_and_finish();
      $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask: tally_and_finish
   task t_reset();
      repeat (19) @(posedge clk);
      #1;
      chk(16'({cke, cs_n, ras_n, cas_n, we_n, read_ok}), 16'h2f);
      chk(16'(pwr_state), 16'(ST_NORMAL));
      @(posedge clk);
      rst_n <= 1'b1;
      $display("test reset done");
   endtask: t_reset
   task t_ppd();
      @(posedge clk);
      pd_req <= 1'b1;
      term_en <= 1'b1;
      term_level <= 1'b1;
      wait_st(ST_POWER_DOWN);
      // Device registers the new enable level one edge after the pins move
      @(posedge clk);
      #1;
      chk(16'({cke, dev_state}), 16'h2);
      repeat (2) @(posedge clk);
      #1;
      chk(16'(term_ctl), 16'h1);
      @(posedge clk);
      pd_req <= 1'b0;
      wait_st(ST_NORMAL);
      @(posedge clk);
      #1;
      chk(16'({cke, dev_state}), 16'h4);
      $display("test precharge power-down done");
   endtask: t_ppd
   task t_apd();
      @(posedge clk);
      bank_open <= 1'b1;
      sr_req <= 1'b1;
      pd_req <= 1'b1;
      wait_st(ST_POWER_DOWN);
      @(posedge clk);
      #1;
      chk(16'(dev_state), 16'h1);
      @(posedge clk);
      bank_open <= 1'b0;
      sr_req <= 1'b0;
      pd_req <= 1'b0;
      wait_st(ST_NORMAL);
      $display("test active power-down done");
   endtask: t_apd
   task t_block();
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         op_busy <= (i == 0);
         cal_mode <= (i == 1);
         pd_req <= 1'b1;
         repeat (10) @(posedge clk);
         #1;
         chk(16'(cke), 16'h1);
         @(posedge clk);
         op_busy <= 1'b0;
         cal_mode <= 1'b0;
         wait_st(ST_POWER_DOWN);
         @(posedge clk);
         pd_req <= 1'b0;
         wait_st(ST_NORMAL);
      end
      $display("test blockers done");
   endtask: t_block
   task t_limit();
      int n;
      @(posedge clk);
      pd_req <= 1'b1;
      wait_st(ST_POWER_DOWN);
      n = 0;
      while (pwr_state === ST_POWER_DOWN && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(n <= 36 && n >= 3), 16'h1);
      @(posedge clk);
      pd_req <= 1'b0;
      wait_st(ST_NORMAL);
      repeat (5) @(posedge clk);
      $display("test power-down limit done");
   endtask: t_limit
   task t_sr();
      int n;
      @(posedge clk);
      sr_req <= 1'b1;
      wait_st(ST_SELF_REF);
      @(posedge clk);
      #1;
      chk(16'(dev_state), 16'h3);
      repeat (3) @(posedge clk);
      #1;
      chk(16'({term_ctl, term_on}), 16'h0);
      @(posedge clk);
      sr_req <= 1'b0;
      wait_st(ST_SR_EXIT);
      chk(16'({read_ok, cmd_ready}), 16'h0);
      n = 0;
      do begin
         @(posedge clk);
         cmd_valid <= 1'b1;
         cmd_in <= CMD_READ;
         #1;
         n++;
      end while ({cs_n, ras_n, cas_n, we_n} !== CMD_READ && n < 400);
      chk(16'(n), 16'd200);
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_in <= CMD_NOP;
      $display("test self-refresh done");
   endtask: t_sr
   task t_cmd();
      cmd_t tbl [4];
      tbl = '{CMD_READ, 4'h4, 4'h3, 4'h2};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         cmd_valid <= 1'b1;
         cmd_in <= tbl[i];
         mask_in <= (i % 2 == 0);
         @(posedge clk);
         cmd_valid <= 1'b0;
         mask_in <= 1'b0;
         #1;
         chk(16'({cs_n, ras_n, cas_n, we_n}), 16'(tbl[i]));
         chk(16'({wr_mask, wr_keep}), (i % 2 == 0) ? 16'h2 : 16'h1);
         @(posedge clk);
         #1;
         chk(16'({cs_n, ras_n, cas_n, we_n}), 16'(CMD_NOP));
      end
      $display("test commands done");
   endtask: t_cmd
   // Main sequence
   initial begin
      t_reset();
      t_ppd();
      t_apd();
      t_block();
      t_limit();
      t_sr();
      t_cmd();
      chk(16'(viol_cnt), 16'h0);
      tally_and_finish();
   end
   // Watchdog
   initial begin
      #300us;
      error_cnt++;
      $display("Error at %0t: watchdog got %h expected %h", $time, 1'b1, 1'b0);
      tally_and_finish();
   end
endmodule: testbench
`default_nettype wire
